// ===== pkg/monres_cfg.svh
// register offsets, field positions, reset values and widths of the result/DAC bank
// assumes inclusion by bare name from package and design files
`ifndef MONRES_CFG_SVH
`define MONRES_CFG_SVH

// register offsets (byte addresses)
`define MR_OFS_TS_LOW      8'h03
`define MR_OFS_AN_LOW      8'h04
`define MR_OFS_SUP_HIGH    8'h06
`define MR_OFS_TEMP_HIGH   8'h07
`define MR_OFS_EXT_HIGH    8'h08
`define MR_OFS_IN2_HIGH    8'h09
`define MR_OFS_IN3_HIGH    8'h0a
`define MR_OFS_IN4_HIGH    8'h0b
`define MR_OFS_DACA_LOW    8'h10
`define MR_OFS_DACA_HIGH   8'h11
`define MR_OFS_DACB_LOW    8'h12
`define MR_OFS_DACB_HIGH   8'h13

// reset values
`define MR_RST_RESULT      10'h000
`define MR_RST_DAC_BYTE    8'h00
`define MR_RST_RDATA       8'h00

// field positions in the low-bits registers
`define MR_POS_TEMP_LSB    0
`define MR_POS_SUP_LSB     2
`define MR_POS_EXT_LSB     0
`define MR_POS_IN2_LSB     2
`define MR_POS_IN3_LSB     4
`define MR_POS_IN4_LSB     6

// input-select field codes
`define MR_SEL_INPUTS      2'b00
`define MR_SEL_EXT_TEMP    2'b10

// DAC code layout: 12-bit variant keeps four low bits in 7:4
`define MR_DAC_BITS        12
`define MR_DAC_LOW_BITS    4

// result slots held by the bank
`define MR_SLOTS           6

`endif

// ===== pkg/monres_pkg.sv
// types shared by the result/DAC register bank
// assumes monres_cfg.svh is on the include path
`include "monres_cfg.svh"

`default_nettype none

package monres_pkg;

  // source of a conversion result
  typedef enum logic [2:0] {
    CH_INT_TEMP,
    CH_SUPPLY,
    CH_EXT_TEMP,
    CH_IN1,
    CH_IN2,
    CH_IN3,
    CH_IN4
  } chan_t;

  // one finished conversion from the sequencer
  typedef struct packed {
    logic       valid;
    chan_t      chan;
    logic [9:0] value;
  } result_t;

  // one register access from the serial port logic
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // read answer back to the serial port logic
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] rdata;
  } reg_rsp_t;

endpackage

`default_nettype wire

// ===== design/result_store.sv
// holds the six 10-bit conversion results of the bank
// assumes results arrive from converter logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "monres_cfg.svh"

module result_store (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire monres_pkg::result_t      res,
  input  wire logic [1:0]               input_select_field,
  output logic [`MR_SLOTS-1:0][9:0]     slot_value
);

  logic [9:0] slot_q [`MR_SLOTS];
  logic [2:0] slot_idx;
  logic       slot_hit;

  // map a result onto its slot; the shared slot follows the input select
  always_comb begin
    slot_idx = 3'd0;
    slot_hit = res.valid;
    unique case (res.chan)
      monres_pkg::CH_INT_TEMP: slot_idx = 3'd0;
      monres_pkg::CH_SUPPLY:   slot_idx = 3'd1;
      monres_pkg::CH_EXT_TEMP: begin
        slot_idx = 3'd2;
        slot_hit = res.valid && (input_select_field == `MR_SEL_EXT_TEMP);
      end
      monres_pkg::CH_IN1:      begin
        slot_idx = 3'd2;
        slot_hit = res.valid && (input_select_field == `MR_SEL_INPUTS);
      end
      monres_pkg::CH_IN2:      slot_idx = 3'd3;
      monres_pkg::CH_IN3:      slot_idx = 3'd4;
      monres_pkg::CH_IN4:      slot_idx = 3'd5;
      default:                 slot_hit = 1'b0;
    endcase
  end

  // capture; supply slot starts at zero until its first measurement lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `MR_SLOTS; i++) begin
        slot_q[i] <= `MR_RST_RESULT;
      end
    end else if (slot_hit) begin
      slot_q[slot_idx] <= res.value;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MR_SLOTS; g++) begin : g_out
      assign slot_value[g] = slot_q[g];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== design/dac_code_reg.sv
// low/high code byte pair of one DAC channel
// assumes write strobes decoded by the bank on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "monres_cfg.svh"

module dac_code_reg (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    wr_low,
  input  wire logic                    wr_high,
  input  wire logic [7:0]              wdata,
  output logic [7:0]                   low_byte,
  output logic [7:0]                   high_byte,
  output logic [`MR_DAC_BITS-1:0]      code
);

  logic [`MR_DAC_LOW_BITS-1:0] low_q;
  logic [7:0]                  high_q;

  // only the implemented top bits of the low byte are stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= '0;
    end else if (wr_low) begin
      low_q <= wdata[7 -: `MR_DAC_LOW_BITS];
    end
  end

  // eight most significant code bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_q <= `MR_RST_DAC_BYTE;
    end else if (wr_high) begin
      high_q <= wdata;
    end
  end

  // unused low bits read back as zero
  assign low_byte  = {low_q, {(8-`MR_DAC_LOW_BITS){1'b0}}};
  assign high_byte = high_q;
  assign code      = {high_q, low_q};

endmodule

`default_nettype wire

// ===== design/monres_bank.sv
// result and DAC code register bank reached through the serial port logic
// assumes requests and results come from logic on the same clock; one request per cycle
`timescale 1ns/1ps
`default_nettype none
`include "monres_cfg.svh"

module monres_bank (
  input  wire logic                     CLK,
  input  wire logic                     RST_B,
  input  wire monres_pkg::reg_req_t     REG_REQ,
  output monres_pkg::reg_rsp_t          REG_RSP,
  input  wire monres_pkg::result_t      RESULT,
  input  wire logic [1:0]               INPUT_SELECT_FIELD,
  output logic [`MR_DAC_BITS-1:0]       DAC_A_CODE,
  output logic [`MR_DAC_BITS-1:0]       DAC_B_CODE,
  output logic                          SUPPLY_LOADED
);

  // slots of the result store, in store order
  localparam int SLOT_INT_TEMP = 0;
  localparam int SLOT_SUPPLY   = 1;
  localparam int SLOT_SHARED   = 2;
  localparam int SLOT_IN2      = 3;
  localparam int SLOT_IN3      = 4;
  localparam int SLOT_IN4      = 5;

  // decoded register kinds
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_RESULT,
    KIND_DAC
  } reg_kind_t;

  // result store outputs and DAC byte pairs
  logic [`MR_SLOTS-1:0][9:0] slot_value;
  logic [7:0]                dac_a_low;
  logic [7:0]                dac_a_high;
  logic [7:0]                dac_b_low;
  logic [7:0]                dac_b_high;

  // write strobes and read data
  logic                      wr_a_low;
  logic                      wr_a_high;
  logic                      wr_b_low;
  logic                      wr_b_high;
  logic [7:0]                rd_mux;

  // selection, supply status and refusal
  logic [1:0]                sel_q;
  logic                      sel_legal;
  logic                      supply_loaded_q;
  logic                      access;
  logic                      bad_access;
  monres_pkg::reg_rsp_t      rsp_d;
  monres_pkg::result_t       res_gated;

  // request decode
  logic                      rd_req;
  logic                      wr_req;
  reg_kind_t                 req_kind;
  logic                      kind_result;
  logic                      kind_none;
  logic                      rd_unmapped;
  logic                      wr_refused;

  // byte views of the stored results
  logic [`MR_SLOTS-1:0][7:0] high_view;
  logic [`MR_SLOTS-1:0][1:0] low_view;
  logic [7:0]                ts_low_view;
  logic [7:0]                an_low_view;

  // answer registers, one per field, and the supply result strobe
  logic                      rsp_valid_q;
  logic                      rsp_err_q;
  logic [7:0]                rsp_rdata_q;
  logic                      supply_result;

  // kind of register behind a byte address
  function automatic reg_kind_t reg_kind(input logic [7:0] addr);
    reg_kind_t k;
    k = KIND_NONE;
    unique case (addr)
      `MR_OFS_TS_LOW,
      `MR_OFS_AN_LOW,
      `MR_OFS_SUP_HIGH,
      `MR_OFS_TEMP_HIGH,
      `MR_OFS_EXT_HIGH,
      `MR_OFS_IN2_HIGH,
      `MR_OFS_IN3_HIGH,
      `MR_OFS_IN4_HIGH:  k = KIND_RESULT;
      `MR_OFS_DACA_LOW,
      `MR_OFS_DACA_HIGH,
      `MR_OFS_DACB_LOW,
      `MR_OFS_DACB_HIGH: k = KIND_DAC;
      default:           k = KIND_NONE;
    endcase
    return k;
  endfunction

  // write strobe for one DAC byte
  function automatic logic dac_write(input monres_pkg::reg_req_t req, input logic [7:0] ofs);
    return req.wr && (req.addr == ofs) && (reg_kind(req.addr) == KIND_DAC);
  endfunction

  // high byte of a 10-bit result
  function automatic logic [7:0] high_of(input logic [9:0] v);
    return v[9:2];
  endfunction

  // two lowest bits of a 10-bit result
  function automatic logic [1:0] low_of(input logic [9:0] v);
    return v[1:0];
  endfunction

  // request qualifiers, decoded once per cycle
  assign rd_req      = REG_REQ.rd;
  assign wr_req      = REG_REQ.wr;
  assign req_kind    = reg_kind(REG_REQ.addr);
  assign kind_result = (req_kind == KIND_RESULT);
  assign kind_none   = (req_kind == KIND_NONE);

  // an undefined select code keeps the last legal choice in force
  assign sel_legal = (INPUT_SELECT_FIELD == `MR_SEL_INPUTS) ||
                     (INPUT_SELECT_FIELD == `MR_SEL_EXT_TEMP);

  // held input selection used for steering the shared slot
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_q <= `MR_SEL_INPUTS;
    end else if (sel_legal) begin
      sel_q <= INPUT_SELECT_FIELD;
    end
  end

  // results of the deselected shared source are not forwarded
  always_comb begin
    res_gated = RESULT;
    if (RESULT.chan == monres_pkg::CH_EXT_TEMP) begin
      res_gated.valid = RESULT.valid && (sel_q == `MR_SEL_EXT_TEMP);
    end else if (RESULT.chan == monres_pkg::CH_IN1) begin
      res_gated.valid = RESULT.valid && (sel_q == `MR_SEL_INPUTS);
    end
  end

  // conversion result storage
  result_store u_results (
    .clk                (CLK),
    .rst_b              (RST_B),
    .res                (res_gated),
    .input_select_field (sel_q),
    .slot_value         (slot_value)
  );

  // a finished supply conversion on the result port
  assign supply_result = RESULT.valid && (RESULT.chan == monres_pkg::CH_SUPPLY);

  // supply register holds a real measurement once the first lands
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      supply_loaded_q <= 1'b0;
    end else if (supply_result) begin
      supply_loaded_q <= 1'b1;
    end
  end

  assign SUPPLY_LOADED = supply_loaded_q;

  // DAC byte write strobes; result registers get none
  assign wr_a_low  = dac_write(REG_REQ, `MR_OFS_DACA_LOW);
  assign wr_a_high = dac_write(REG_REQ, `MR_OFS_DACA_HIGH);
  assign wr_b_low  = dac_write(REG_REQ, `MR_OFS_DACB_LOW);
  assign wr_b_high = dac_write(REG_REQ, `MR_OFS_DACB_HIGH);

  // channel A code pair
  dac_code_reg u_dac_a (
    .clk       (CLK),
    .rst_b     (RST_B),
    .wr_low    (wr_a_low),
    .wr_high   (wr_a_high),
    .wdata     (REG_REQ.wdata),
    .low_byte  (dac_a_low),
    .high_byte (dac_a_high),
    .code      (DAC_A_CODE)
  );

  // channel B code pair, same layout as A
  dac_code_reg u_dac_b (
    .clk       (CLK),
    .rst_b     (RST_B),
    .wr_low    (wr_b_low),
    .wr_high   (wr_b_high),
    .wdata     (REG_REQ.wdata),
    .low_byte  (dac_b_low),
    .high_byte (dac_b_high),
    .code      (DAC_B_CODE)
  );

  // high and low fields of every stored result
  // one view pair per slot; a new slot still needs its own entry in the read mux
  genvar s;
  generate
    for (s = 0; s < `MR_SLOTS; s++) begin : g_view
      assign high_view[s] = high_of(slot_value[s]);
      assign low_view[s]  = low_of(slot_value[s]);
    end
  endgenerate

  // internal temperature and supply low bits; 7:4 stay zero
  always_comb begin
    ts_low_view                        = 8'h00;
    ts_low_view[`MR_POS_TEMP_LSB +: 2] = low_view[SLOT_INT_TEMP];
    ts_low_view[`MR_POS_SUP_LSB +: 2]  = low_view[SLOT_SUPPLY];
  end

  // shared source and inputs two to four, one bit pair each
  always_comb begin
    an_low_view                       = 8'h00;
    an_low_view[`MR_POS_EXT_LSB +: 2] = low_view[SLOT_SHARED];
    an_low_view[`MR_POS_IN2_LSB +: 2] = low_view[SLOT_IN2];
    an_low_view[`MR_POS_IN3_LSB +: 2] = low_view[SLOT_IN3];
    an_low_view[`MR_POS_IN4_LSB +: 2] = low_view[SLOT_IN4];
  end

  // read data selection; unmapped and unused bits give zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (REG_REQ.addr)
      `MR_OFS_TS_LOW: begin
        rd_mux = ts_low_view;
      end
      `MR_OFS_AN_LOW: begin
        rd_mux = an_low_view;
      end
      `MR_OFS_SUP_HIGH: begin
        rd_mux = high_view[SLOT_SUPPLY];
      end
      `MR_OFS_TEMP_HIGH: begin
        rd_mux = high_view[SLOT_INT_TEMP];
      end
      `MR_OFS_EXT_HIGH: begin
        rd_mux = high_view[SLOT_SHARED];
      end
      `MR_OFS_IN2_HIGH: begin
        rd_mux = high_view[SLOT_IN2];
      end
      `MR_OFS_IN3_HIGH: begin
        rd_mux = high_view[SLOT_IN3];
      end
      `MR_OFS_IN4_HIGH: begin
        rd_mux = high_view[SLOT_IN4];
      end
      `MR_OFS_DACA_LOW: begin
        rd_mux = dac_a_low;
      end
      `MR_OFS_DACA_HIGH: begin
        rd_mux = dac_a_high;
      end
      `MR_OFS_DACB_LOW: begin
        rd_mux = dac_b_low;
      end
      `MR_OFS_DACB_HIGH: begin
        rd_mux = dac_b_high;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // an access is refused when unmapped, or a write to a result register
  assign access      = rd_req || wr_req;

  // reads of unmapped bytes answer zero with the refusal flag
  assign rd_unmapped = rd_req && kind_none;

  // writes land only on DAC bytes; result registers keep their value
  assign wr_refused  = wr_req && (kind_none || kind_result);
  assign bad_access  = rd_unmapped || wr_refused;

  // answer of the current request
  always_comb begin
    rsp_d       = '0;
    rsp_d.valid = access;
    rsp_d.err   = bad_access;
    rsp_d.rdata = REG_REQ.rd ? rd_mux : `MR_RST_RDATA;
  end

  // answer valid, one cycle after the request
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= rsp_d.valid;
    end
  end

  // refusal flag, standing with valid only
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_err_q <= 1'b0;
    end else begin
      rsp_err_q <= rsp_d.err;
    end
  end

  // read data, zero for writes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_rdata_q <= `MR_RST_RDATA;
    end else begin
      rsp_rdata_q <= rsp_d.rdata;
    end
  end

  // answer fields gathered onto the port
  always_comb begin
    REG_RSP       = '0;
    REG_RSP.valid = rsp_valid_q;
    REG_RSP.err   = rsp_err_q;
    REG_RSP.rdata = rsp_rdata_q;
  end

endmodule

`default_nettype wire

// ===== testbench/monres_monitor.sv
// checker for the result/DAC register bank ports
// assumes a bind onto monres_bank from the bench top
`timescale 1ns/1ps
`default_nettype none
`include "monres_cfg.svh"
module monres_monitor (
  input wire logic                    CLK,
  input wire logic                    RST_B,
  input wire monres_pkg::reg_req_t    REG_REQ,
  input wire monres_pkg::reg_rsp_t    REG_RSP,
  input wire monres_pkg::result_t     RESULT,
  input wire logic [1:0]              INPUT_SELECT_FIELD,
  input wire logic [`MR_DAC_BITS-1:0] DAC_A_CODE,
  input wire logic [`MR_DAC_BITS-1:0] DAC_B_CODE,
  input wire logic                    SUPPLY_LOADED
);
  // request decode helpers
  logic       req;
  logic       ro_wr;
  logic       wa;
  logic [3:0] wd_hi;
  assign req = REG_REQ.rd | REG_REQ.wr;
  assign ro_wr = REG_REQ.wr && REG_REQ.addr inside {8'h03, 8'h04, [8'h06:8'h0b]};
  assign wa = REG_REQ.wr && REG_REQ.addr[7:1] == 7'h08;
  assign wd_hi = REG_REQ.wdata[7:4];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_ans; req |=> REG_RSP.valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idle; !req |=> !REG_RSP.valid; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_ro; ro_wr |=> REG_RSP.err && $stable(DAC_A_CODE) && $stable(DAC_B_CODE); endproperty
  a_ro: assert property (p_ro) else $error("read-only write not refused");
  property p_ahi; REG_REQ.wr && REG_REQ.addr == 8'h11 |=> DAC_A_CODE[11:4] == $past(REG_REQ.wdata); endproperty
  a_ahi: assert property (p_ahi) else $error("dac a high wrong");
  property p_alo; REG_REQ.wr && REG_REQ.addr == 8'h10 |=> DAC_A_CODE[3:0] == $past(wd_hi); endproperty
  a_alo: assert property (p_alo) else $error("dac a low wrong");
  property p_blo; REG_REQ.wr && REG_REQ.addr == 8'h12 |=> DAC_B_CODE[3:0] == $past(wd_hi); endproperty
  a_blo: assert property (p_blo) else $error("dac b low wrong");
  property p_bhi; REG_REQ.wr && REG_REQ.addr == 8'h13 |=> DAC_B_CODE[11:4] == $past(REG_REQ.wdata); endproperty
  a_bhi: assert property (p_bhi) else $error("dac b high wrong");
  property p_hold; !wa |=> $stable(DAC_A_CODE); endproperty
  a_hold: assert property (p_hold) else $error("dac a moved");
  property p_sup; RESULT.valid && RESULT.chan == monres_pkg::CH_SUPPLY |=> SUPPLY_LOADED; endproperty
  a_sup: assert property (p_sup) else $error("supply not loaded");
  property p_rst; $rose(RST_B) |-> DAC_A_CODE == 12'h000 && DAC_B_CODE == 12'h000; endproperty
  a_rst: assert property (p_rst) else $error("dac not zero after reset");
endmodule
`default_nettype wire

// ===== testbench/conv_src.sv
// model of the converter sequencer and the select configuration
// assumes tasks are called at a clock edge plus 1 ns
`timescale 1ns/1ps
`default_nettype none
module conv_src (
  input  wire logic           clk,
  output monres_pkg::result_t res,
  output logic [1:0]          sel
);
  // idle at time zero
  initial begin
    res = '0;
    sel = 2'b00;
  end
  // one result, back to back allowed
  task automatic send(input monres_pkg::chan_t c, input logic [9:0] v);
    res = {1'b1, c, v};
    @(posedge clk);
    #1;
  endtask
  // end of a result burst
  task automatic done();
    res.valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // only the two defined select codes are written
  task automatic set(input logic [1:0] s);
    sel = s;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== testbench/monres_bank_tb_top.sv
// self-checking bench for the result/DAC register bank
// assumes package, partner model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module monres_bank_tb_top;
  logic                 clk;
  logic                 rst_b;
  monres_pkg::reg_req_t req;
  monres_pkg::reg_rsp_t rsp;
  monres_pkg::result_t  res;
  logic [1:0]           sel;
  logic [11:0]          dac_a;
  logic [11:0]          dac_b;
  logic                 sup_ok;
  logic [8:0]           e;
  logic [31:0]          r;
  logic [31:0]          rs = 32'hd1c5_ed0d;
  logic [7:0]           m [256] = '{default: 8'h00};
  logic [8:0]           expq [$];
  int                   hi_ofs [7] = '{7, 6, 8, 8, 9, 10, 11};
  int                   lo_pos [7] = '{0, 2, 0, 0, 2, 4, 6};
  int                   n_fail = 0;
  int                   n_tests = 0;

  monres_bank dut (.CLK(clk), .RST_B(rst_b), .REG_REQ(req), .REG_RSP(rsp), .RESULT(res),
    .INPUT_SELECT_FIELD(sel), .DAC_A_CODE(dac_a), .DAC_B_CODE(dac_b), .SUPPLY_LOADED(sup_ok));
  conv_src src (.clk(clk), .res(res), .sel(sel));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(input string n, input logic [11:0] x, input logic [11:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one access per cycle; the answer is noted before it is sent
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    ok = a inside {8'h03, 8'h04, [8'h06:8'h0b], [8'h10:8'h13]};
    req = {w, !w, a, d};
    expq.push_back({!ok || (w && a < 8'h10), w ? 8'h00 : m[a]});
    if (w && ok && a >= 8'h10)
      m[a] = a[0] ? d : d & 8'hf0;
    @(posedge clk);
    #1;
  endtask

  task automatic idle();
    req = '0;
    @(posedge clk);
    #1;
  endtask

  // read offsets 0 to 31, unmapped ones included
  task automatic scan();
    for (int a = 0; a < 32; a++) acc(1'b0, 8'(a), 8'h00);
    idle();
  endtask

  // one result; deselected shared sources are dropped
  task automatic put(input int i, input logic [9:0] v);
    src.send(monres_pkg::chan_t'(i), v);
    if (!(i == 2 && sel != 2'b10) && !(i == 3 && sel != 2'b00)) begin
      m[hi_ofs[i]] = v[9:2];
      m[i < 2 ? 3 : 4][lo_pos[i] +: 2] = v[1:0];
    end
  endtask

  task automatic burst();
    for (int i = 0; i < 7; i++) begin
      r = rnd();
      put(i, r[9:0]);
    end
    src.done();
    scan();
  endtask

  // response watcher: oldest note against each answer, mid-cycle
  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : 9'h1ff;
      chk("err", e[8], rsp.err);
      chk("rdata", e[7:0], rsp.rdata);
    end
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    req = '0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    scan();
    chk("supply loaded", 12'h000, sup_ok);
    burst();
    chk("supply loaded", 12'h001, sup_ok);
    src.set(2'b10);
    burst();
    for (int a = 3; a < 20; a++) begin
      r = rnd();
      acc(1'b1, 8'(a), r[7:0]);
    end
    idle();
    chk("dac a", {m[17], m[16][7:4]}, dac_a);
    chk("dac b", {m[19], m[18][7:4]}, dac_b);
    scan();
    rst_b = 1'b0;
    #1;
    chk("dac a reset", 12'h000, dac_a);
    chk("dac b reset", 12'h000, dac_b);
    chk("supply reset", 12'h000, sup_ok);
    m = '{default: 8'h00};
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    src.set(2'b00);
    scan();
    chk("answers left", 12'h000, 12'(expq.size()));
    test_done();
  end

  // watchdog
  initial begin
    #50us;
    n_fail++;
    test_done();
  end
endmodule

bind monres_bank monres_monitor mon (.CLK(CLK), .RST_B(RST_B), .REG_REQ(REG_REQ), .REG_RSP(REG_RSP),
  .RESULT(RESULT), .INPUT_SELECT_FIELD(INPUT_SELECT_FIELD), .DAC_A_CODE(DAC_A_CODE),
  .DAC_B_CODE(DAC_B_CODE), .SUPPLY_LOADED(SUPPLY_LOADED));
`default_nettype wire
